//--- logic/cosc_output_stage.sv
// clock output stage: divider crosspoint, driver gating, parking, polarity and drive select
// Behaviour
// - global enable pin high disables all drivers; low enables them.
// - each globally enabled output can still be disabled by its own register bit.
// - per output, a disabled driver parks low or high as configured.
// - with synchronous disable on, disabling waits until the running high phase of the source ends.
// - with synchronous disable off, the output stops at once.
// - crosspoint routes any divider to any driver; routing has power-up defaults.
// - single-ended mode drives both pins, in phase by default.
// - polarity of each single-ended pin is configurable.
// - drive select takes 1, 2 or 3; 1 is refused on a 1.8 V supply.
// - any output may be differential or single-ended, up to 20 single-ended pins.
// - all output dividers start from one common state after power-up.
// - reset pin or hard reset bit resets all dividers to that same state.
// - zero delay mode opens the internal feedback; board closes loop externally.
// - hitless input switching is withheld while zero delay mode is on.
// - unused inputs and drivers can be powered down by configuration.
`timescale 1ns/100ps

module cosc_output_stage
  import cosc_pkg::*;
#(
  parameter int NOUT = NUM_OUT,
  parameter int NDIV = NUM_DIV
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire cosc_bus_req_s       busReq,
  output logic [31:0]              busRdata,
  input  wire logic                globalOutputGate_n,
  input  wire logic                chipReset_n,
  input  wire logic [NOUT-1:0]     vddoIs1v8,
  output logic [NOUT-1:0]          trueOutputPin,
  output logic [NOUT-1:0]          complementOutputPin,
  output logic [2*NOUT-1:0]        singleEndedDriveSelect,
  output logic [NOUT-1:0]          singleEndedMode,
  output logic [NOUT-1:0]          outputPowerDown,
  output logic [NUM_IN-1:0]        inputPowerDown,
  output logic                     externalFeedbackSelect,
  output logic                     hitlessSwitchEnable
);

  // legal drive value: a refused write keeps the previous selection
  function automatic logic [1:0] legalDrive(input logic [1:0] req, input logic [1:0] old,
                                            input logic is1v8);
    if (req == 2'h0 || (req == 2'h1 && is1v8)) begin
      return old;
    end
    return req;
  endfunction

  logic             gateSync1_ff, gateSync2_ff;
  logic [1:0]       rstSync_ff;
  logic [NOUT-1:0]  vddoSync1_ff, vddoSync2_ff;
  logic [2:0]       ctrl_ff;
  logic [NOUT-1:0]  outDis_ff, syncDis_ff, parkHigh_ff, seMode_ff, polTrue_ff, polComp_ff;
  logic [NOUT-1:0]  pdOut_ff, outEn_ff, gateReq_ff;
  logic [NUM_IN-1:0] pdIn_ff;
  logic [SEL_W-1:0] xsel_ff [NOUT];
  logic [1:0]       drv_ff [NOUT];
  logic [DIV_W-1:0] divHalf_ff [NDIV];
  logic [DIV_W-1:0] divCnt_ff [NDIV];
  logic [NDIV-1:0]  divLvl_ff;
  logic [NOUT-1:0]  srcLvl;
  logic [NOUT-1:0]  nxt_outEn;
  logic             gateSync;
  logic             divReset;
  logic             hardRstPulse;
  logic [31:0]      nxt_busRdata;

  assign gateSync = gateSync2_ff;
  assign hardRstPulse = ctrl_ff[BIT_HARD_RST];
  assign divReset = hardRstPulse | ~rstSync_ff[1];

  // pins from outside pass two flops before any logic looks at them
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gateSync1_ff <= 1'b1;
      gateSync2_ff <= 1'b1;
      rstSync_ff   <= 2'h0;
      vddoSync1_ff <= '0;
      vddoSync2_ff <= '0;
    end else begin
      gateSync1_ff <= globalOutputGate_n;
      gateSync2_ff <= gateSync1_ff;
      rstSync_ff   <= {rstSync_ff[0], chipReset_n};
      vddoSync1_ff <= vddoIs1v8;
      vddoSync2_ff <= vddoSync1_ff;
    end
  end

  // register writes; hard reset bit clears itself after one cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_ff     <= 3'h0;
      outDis_ff   <= RST_OUT_DIS;
      syncDis_ff  <= '1;
      parkHigh_ff <= '0;
      seMode_ff   <= '0;
      polTrue_ff  <= '0;
      polComp_ff  <= '0;
      pdOut_ff    <= '0;
      pdIn_ff     <= '0;
    end else begin
      ctrl_ff[BIT_HARD_RST] <= 1'b0;
      if (busReq.wr) begin
        case (busReq.addr)
          OFS_CTRL:     ctrl_ff     <= busReq.wdata[2:0];
          OFS_OUT_DIS:  outDis_ff   <= busReq.wdata[NOUT-1:0];
          OFS_SYNC_DIS: syncDis_ff  <= busReq.wdata[NOUT-1:0];
          OFS_PARK_HI:  parkHigh_ff <= busReq.wdata[NOUT-1:0];
          OFS_SE_MODE:  seMode_ff   <= busReq.wdata[NOUT-1:0];
          OFS_POL_TRUE: polTrue_ff  <= busReq.wdata[NOUT-1:0];
          OFS_POL_COMP: polComp_ff  <= busReq.wdata[NOUT-1:0];
          OFS_PWR_DOWN: begin
            pdOut_ff <= busReq.wdata[NOUT-1:0];
            pdIn_ff  <= busReq.wdata[POS_PD_IN +: NUM_IN];
          end
          default: ;
        endcase
      end
    end
  end

  // crosspoint and drive fields; reset routing is the power-up configuration
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NOUT; i++) begin
        xsel_ff[i] <= SEL_W'(i % NDIV);
        drv_ff[i]  <= RST_DRV;
      end
    end else begin
      for (int i = 0; i < NOUT; i++) begin
        if (busReq.wr && busReq.addr == OFS_OUT_CFG + 8'(4 * i)) begin
          xsel_ff[i] <= busReq.wdata[POS_SEL +: SEL_W];
          drv_ff[i]  <= legalDrive(busReq.wdata[POS_DRV +: 2], drv_ff[i],
                                   vddoSync2_ff[i]);
        end else if (drv_ff[i] == 2'h1 && vddoSync2_ff[i]) begin
          drv_ff[i] <= 2'h2;
        end
      end
    end
  end

  // dividers: half period of zero holds the divider still
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int d = 0; d < NDIV; d++) begin
        divHalf_ff[d] <= RST_DIV_HALF;
        divCnt_ff[d]  <= '0;
      end
      divLvl_ff <= '0;
    end else begin
      for (int d = 0; d < NDIV; d++) begin
        if (busReq.wr && busReq.addr == OFS_DIV_HALF + 8'(4 * d)) begin
          divHalf_ff[d] <= busReq.wdata[DIV_W-1:0];
        end
        if (divReset) begin
          divCnt_ff[d] <= '0;
          divLvl_ff[d] <= 1'b0;
        end else if (divHalf_ff[d] != '0) begin
          if (divCnt_ff[d] >= divHalf_ff[d] - DIV_W'(1)) begin
            divCnt_ff[d] <= '0;
            divLvl_ff[d] <= ~divLvl_ff[d];
          end else begin
            divCnt_ff[d] <= divCnt_ff[d] + DIV_W'(1);
          end
        end
      end
    end
  end

  // gating: a synchronous disable lets the running high phase finish first,
  // so the driver only parks once the source is back low
  always_comb begin
    for (int i = 0; i < NOUT; i++) begin
      srcLvl[i] = (int'(xsel_ff[i]) < NDIV) ? divLvl_ff[xsel_ff[i]] : 1'b0;
      if (gateReq_ff[i]) begin
        nxt_outEn[i] = 1'b1;
      end else if (syncDis_ff[i] && outEn_ff[i] && srcLvl[i]) begin
        nxt_outEn[i] = 1'b1;
      end else begin
        nxt_outEn[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gateReq_ff <= '0;
      outEn_ff   <= '0;
    end else begin
      gateReq_ff <= ~({NOUT{gateSync}} | outDis_ff | pdOut_ff);
      outEn_ff   <= nxt_outEn;
    end
  end

  // pins: enabled drivers follow their source, disabled ones sit at the park level
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trueOutputPin       <= '0;
      complementOutputPin <= '0;
    end else begin
      for (int i = 0; i < NOUT; i++) begin
        if (!outEn_ff[i]) begin
          trueOutputPin[i]       <= parkHigh_ff[i];
          complementOutputPin[i] <= seMode_ff[i] ? parkHigh_ff[i] : ~parkHigh_ff[i];
        end else if (seMode_ff[i]) begin
          trueOutputPin[i]       <= srcLvl[i] ^ polTrue_ff[i];
          complementOutputPin[i] <= srcLvl[i] ^ polComp_ff[i];
        end else begin
          trueOutputPin[i]       <= srcLvl[i];
          complementOutputPin[i] <= ~srcLvl[i];
        end
      end
    end
  end

  // static configuration outputs, registered
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      singleEndedDriveSelect <= '0;
      singleEndedMode        <= '0;
      outputPowerDown        <= '0;
      inputPowerDown         <= '0;
      externalFeedbackSelect <= 1'b0;
      hitlessSwitchEnable    <= 1'b0;
    end else begin
      for (int i = 0; i < NOUT; i++) begin
        singleEndedDriveSelect[2*i +: 2] <= drv_ff[i];
      end
      singleEndedMode        <= seMode_ff;
      outputPowerDown        <= pdOut_ff;
      inputPowerDown         <= pdIn_ff;
      externalFeedbackSelect <= ctrl_ff[BIT_ZERO_DLY];
      hitlessSwitchEnable    <= ctrl_ff[BIT_HITLESS] & ~ctrl_ff[BIT_ZERO_DLY];
    end
  end

  // read port: data stand in the cycle after the strobe only
  always_comb begin
    nxt_busRdata = 32'h0;
    case (busReq.addr)
      OFS_CTRL:     nxt_busRdata[2:0]      = ctrl_ff;
      OFS_OUT_DIS:  nxt_busRdata[NOUT-1:0] = outDis_ff;
      OFS_SYNC_DIS: nxt_busRdata[NOUT-1:0] = syncDis_ff;
      OFS_PARK_HI:  nxt_busRdata[NOUT-1:0] = parkHigh_ff;
      OFS_SE_MODE:  nxt_busRdata[NOUT-1:0] = seMode_ff;
      OFS_POL_TRUE: nxt_busRdata[NOUT-1:0] = polTrue_ff;
      OFS_POL_COMP: nxt_busRdata[NOUT-1:0] = polComp_ff;
      OFS_PWR_DOWN: begin
        nxt_busRdata[NOUT-1:0]             = pdOut_ff;
        nxt_busRdata[POS_PD_IN +: NUM_IN]  = pdIn_ff;
      end
      OFS_STATUS: begin
        nxt_busRdata[NOUT-1:0]   = outEn_ff;
        nxt_busRdata[POS_ST_ZDM]  = ctrl_ff[BIT_ZERO_DLY];
        nxt_busRdata[POS_ST_HITL] = ctrl_ff[BIT_HITLESS] & ~ctrl_ff[BIT_ZERO_DLY];
      end
      default: begin
        for (int i = 0; i < NOUT; i++) begin
          if (busReq.addr == OFS_OUT_CFG + 8'(4 * i)) begin
            nxt_busRdata[POS_SEL +: SEL_W] = xsel_ff[i];
            nxt_busRdata[POS_DRV +: 2]     = drv_ff[i];
          end
        end
        for (int d = 0; d < NDIV; d++) begin
          if (busReq.addr == OFS_DIV_HALF + 8'(4 * d)) begin
            nxt_busRdata[DIV_W-1:0] = divHalf_ff[d];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busRdata <= 32'h0;
    end else begin
      busRdata <= busReq.rd ? nxt_busRdata : 32'h0;
    end
  end

  a_global_gate_off: assert property (@(posedge clock) disable iff (rst)
    (gateSync && !syncDis_ff[0]) |=> ##1 !outEn_ff[0])
    else $error("global gate high did not stop output 0");

  a_reg_disable_off: assert property (@(posedge clock) disable iff (rst)
    (outDis_ff[0] && !syncDis_ff[0]) ##1 (outDis_ff[0] && !syncDis_ff[0]) |=> !outEn_ff[0])
    else $error("register disable did not stop output 0");

  a_park_level_held: assert property (@(posedge clock) disable iff (rst)
    !outEn_ff[0] |=> trueOutputPin[0] == $past(parkHigh_ff[0]))
    else $error("disabled output 0 not at park level");

  a_sync_wait_high: assert property (@(posedge clock) disable iff (rst)
    (outEn_ff[0] && syncDis_ff[0] && srcLvl[0]) |=> outEn_ff[0])
    else $error("synchronous disable cut a high phase");

  a_immediate_stop: assert property (@(posedge clock) disable iff (rst)
    (!gateReq_ff[0] && !syncDis_ff[0]) |=> !outEn_ff[0])
    else $error("immediate disable was delayed");

  a_route_true_pin: assert property (@(posedge clock) disable iff (rst)
    (outEn_ff[0] && seMode_ff[0]) |=> trueOutputPin[0] == $past(srcLvl[0] ^ polTrue_ff[0]))
    else $error("true pin does not follow routed divider");

  a_comp_pin_phase: assert property (@(posedge clock) disable iff (rst)
    (outEn_ff[0] && seMode_ff[0] && polTrue_ff[0] == polComp_ff[0])
      |=> trueOutputPin[0] == complementOutputPin[0])
    else $error("single-ended pins not in phase");

  a_drive_legal_val: assert property (@(posedge clock) disable iff (rst)
    $past(vddoSync2_ff[0], 2) |-> ##1 singleEndedDriveSelect[1:0] != 2'h1)
    else $error("weak drive offered on low supply");

  a_div_common_rst: assert property (@(posedge clock) disable iff (rst)
    divReset |=> (divCnt_ff[0] == '0 && divLvl_ff == '0))
    else $error("dividers not reset together");

  a_no_hitless_zdm: assert property (@(posedge clock) disable iff (rst)
    ctrl_ff[BIT_ZERO_DLY] |=> !hitlessSwitchEnable && externalFeedbackSelect)
    else $error("hitless switching offered in zero delay mode");

endmodule

//--- logic/cosc_pkg.sv
// package: register map, reset values and bus carrier for the clock output stage
package cosc_pkg;

  localparam int NUM_OUT     = 10;
  localparam int NUM_DIV     = 5;
  localparam int NUM_IN      = 4;
  localparam int DIV_W       = 16;
  localparam int SEL_W       = 3;
  localparam int MAX_SE_PINS = 20;

  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_OUT_DIS  = 8'h04;
  localparam logic [7:0] OFS_SYNC_DIS = 8'h08;
  localparam logic [7:0] OFS_PARK_HI  = 8'h0c;
  localparam logic [7:0] OFS_SE_MODE  = 8'h10;
  localparam logic [7:0] OFS_POL_TRUE = 8'h14;
  localparam logic [7:0] OFS_POL_COMP = 8'h18;
  localparam logic [7:0] OFS_PWR_DOWN = 8'h1c;
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  localparam logic [7:0] OFS_OUT_CFG  = 8'h40;
  localparam logic [7:0] OFS_DIV_HALF = 8'h80;

  localparam int BIT_HARD_RST  = 0;
  localparam int BIT_ZERO_DLY  = 1;
  localparam int BIT_HITLESS   = 2;
  localparam int POS_SEL       = 0;
  localparam int POS_DRV       = 4;
  localparam int POS_PD_IN     = 16;
  localparam int POS_ST_ZDM    = 16;
  localparam int POS_ST_HITL   = 17;

  localparam logic [1:0]       RST_DRV      = 2'h3;
  localparam logic [DIV_W-1:0] RST_DIV_HALF = 16'h0004;
  localparam logic [NUM_OUT-1:0] RST_OUT_DIS = 10'h000;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cosc_bus_req_s;

endpackage

//--- bench/cosc_clk_receiver.sv
// far-side model: clock receivers on every output and the board feedback route
`timescale 1ns/100ps
module cosc_clk_receiver #(
  parameter int N = 10
) (
  input  wire logic         clock,
  input  wire logic [N-1:0] truePin,
  input  wire logic         fbSelect,
  output logic              feedbackClock,
  output logic [7:0]        lastHigh [N]
);
  logic [7:0] run [N];
  // the board loops the last driver back only while the internal loop is open
  assign feedbackClock = fbSelect ? truePin[N-1] : 1'b0;
  initial begin
    for (int i = 0; i < N; i++) begin
      run[i] = 8'h00;
    end
  end
  // high-pulse length in system cycles; a runt shows as a short pulse
  always @(posedge clock) begin
    for (int i = 0; i < N; i++) begin
      if (truePin[i]) begin
        run[i] <= run[i] + 8'h01;
      end else begin
        if (run[i] != 8'h00) begin
          lastHigh[i] <= run[i];
        end
        run[i] <= 8'h00;
      end
    end
  end
endmodule

//--- bench/tb_clock_output_stage.sv
// self-checking bench of the clock output stage
`timescale 1ns/100ps
module tb_clock_output_stage_control
  import cosc_pkg::*;
;
  logic                 clock, rst, globalOutputGate_n, chipReset_n, fb, hl, fbClk;
  cosc_bus_req_s        busReq;
  logic [31:0]          busRdata, seed, rd;
  logic [NUM_OUT-1:0]   vddoIs1v8, tPin, cPin, seMode, outPd, pt, pc, hiSeen;
  logic [2*NUM_OUT-1:0] drvSel;
  logic [NUM_IN-1:0]    inPd;
  logic [2:0]           sel;
  logic [7:0]           lastHigh [NUM_OUT];
  logic [7:0]           expHalf [NUM_OUT];
  int                   err_total, comparisons;

  cosc_output_stage #(.NOUT(NUM_OUT), .NDIV(NUM_DIV)) i_dut (
    .clock(clock), .rst(rst), .busReq(busReq), .busRdata(busRdata),
    .globalOutputGate_n(globalOutputGate_n), .chipReset_n(chipReset_n),
    .vddoIs1v8(vddoIs1v8), .trueOutputPin(tPin), .complementOutputPin(cPin),
    .singleEndedDriveSelect(drvSel), .singleEndedMode(seMode),
    .outputPowerDown(outPd), .inputPowerDown(inPd),
    .externalFeedbackSelect(fb), .hitlessSwitchEnable(hl));
  cosc_clk_receiver #(.N(NUM_OUT)) i_rx (.clock(clock), .truePin(tPin),
    .fbSelect(fb), .feedbackClock(fbClk), .lastHigh(lastHigh));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, w, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    busReq.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic br(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    busReq.rd <= 1'b0;
    #1 d = busRdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string w);
    br(a, rd);
    chk(rd, e, w);
  endtask
  // differential: a parked complement sits at the inverse park level
  task automatic hold(input logic [NUM_OUT-1:0] m, input logic [NUM_OUT-1:0] v, string w);
    repeat (8) begin
      @(posedge clock);
      #1 chk(32'({cPin & m, tPin & m}), 32'({~v & m, v & m}), w);
    end
  endtask
  task automatic aligned(input string w);
    repeat (8) begin
      @(posedge clock);
      #1 chk(32'(tPin == {NUM_OUT{tPin[0]}}), 32'h1, w);
    end
  endtask
  task automatic drv(input logic [31:0] w, input logic [31:0] e);
    bw(OFS_OUT_CFG, w);
    rchk(OFS_OUT_CFG, e, "drive");
    chk(32'(drvSel[1:0]), e >> 4, "drive pins");
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    print_verdict;
  end

  initial begin
    busReq = '0;
    rst = 1'b1;
    globalOutputGate_n = 1'b1;
    chipReset_n = 1'b1;
    vddoIs1v8 = '0;
    seed = 32'hd99cf19e;
    err_total = 0;
    comparisons = 0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    hold('1, '0, "gated");
    rchk(OFS_STATUS, 32'h0, "status off");
    rchk(OFS_SYNC_DIS, 32'h3ff, "sync reset");
    rchk(8'h3c, 32'h0, "unmapped");
    for (int i = 0; i < NUM_OUT; i++) begin
      rchk(OFS_OUT_CFG + 8'(4 * i), {26'h0, RST_DRV, 1'b0, 3'(i % NUM_DIV)}, "cfg");
    end
    for (int d = 0; d < NUM_DIV; d++) begin
      rchk(OFS_DIV_HALF + 8'(4 * d), 32'(RST_DIV_HALF), "div");
    end
    globalOutputGate_n <= 1'b0;
    cyc(12);
    rchk(OFS_STATUS, 32'h3ff, "status on");
    $display("test gate done");
    // disable lands two cycles into an eight-cycle high phase
    bw(OFS_DIV_HALF, 32'h8);
    // synchronous case first: the re-enable may start mid-phase, which only
    // the immediate case tolerates; it also leaves all outputs immediate
    for (int s = 1; s >= 0; s--) begin
      bw(OFS_SYNC_DIS, 32'(s));
      @(posedge tPin[0]);
      bw(OFS_OUT_DIS, 32'h1);
      cyc(5);
      #1 chk(32'(tPin[0]), 32'(s), "disable edge");
      cyc(20);
      #1 chk(32'(lastHigh[0] == 8'h8), 32'(s), "runt");
      bw(OFS_OUT_DIS, 32'h0);
    end
    bw(OFS_PARK_HI, 32'h2);
    bw(OFS_OUT_DIS, 32'h2);
    bw(OFS_PWR_DOWN, 32'h000f0004);
    cyc(6);
    hold(10'h6, 10'h2, "park");
    chk(32'({inPd, outPd}), 32'h3c04, "power down");
    bw(OFS_OUT_DIS, 32'h0);
    bw(OFS_PWR_DOWN, 32'h0);
    $display("test disable done");
    for (int d = 0; d < NUM_DIV; d++) begin
      bw(OFS_DIV_HALF + 8'(4 * d), 32'(2 + d));
    end
    for (int i = 0; i < NUM_OUT; i++) begin
      seed = lfsr(seed);
      sel = (i == NUM_OUT - 1) ? 3'h7 : 3'(seed[7:0] % NUM_DIV);
      bw(OFS_OUT_CFG + 8'(4 * i), {26'h0, RST_DRV, 1'b0, sel});
      expHalf[i] = (sel < 3'(NUM_DIV)) ? 8'(2 + sel) : 8'h0;
    end
    // an out-of-range select gives a dead source, so that pin must stay low
    hiSeen = '0;
    repeat (40) begin
      @(posedge clock);
      #1 hiSeen = hiSeen | tPin;
    end
    for (int i = 0; i < NUM_OUT; i++) begin
      chk((expHalf[i] != 8'h0) ? 32'(lastHigh[i]) : 32'(hiSeen[i]), 32'(expHalf[i]), "route");
    end
    bw(OFS_OUT_CFG + 8'(4 * (NUM_OUT - 1)), {26'h0, RST_DRV, 4'h4});
    for (int d = 0; d < NUM_DIV; d++) begin
      bw(OFS_DIV_HALF + 8'(4 * d), 32'h3);
    end
    bw(OFS_CTRL, 32'h1);
    cyc(8);
    aligned("hard reset");
    bw(OFS_DIV_HALF + 8'h4, 32'h5);
    cyc(7);
    bw(OFS_DIV_HALF + 8'h4, 32'h3);
    chipReset_n <= 1'b0;
    cyc(6);
    chipReset_n <= 1'b1;
    cyc(8);
    aligned("reset pin");
    $display("test routing done");
    drv(32'h10, 32'h10);
    drv(32'h00, 32'h10);
    vddoIs1v8 <= 10'h1;
    cyc(6);
    rchk(OFS_OUT_CFG, 32'h20, "forced");
    drv(32'h10, 32'h20);
    drv(32'h30, 32'h30);
    bw(OFS_CTRL, 32'h4);
    br(OFS_STATUS, rd);
    chk(32'({fb, hl, rd[17:16]}), 32'h6, "hitless");
    bw(OFS_CTRL, 32'h6);
    br(OFS_STATUS, rd);
    chk(32'({fb, hl, rd[17:16]}), 32'h9, "zero delay");
    chk(32'(fbClk == tPin[NUM_OUT-1]), 32'h1, "feedback loop");
    globalOutputGate_n <= 1'b1;
    cyc(8);
    hold('1, 10'h2, "gate off");
    $display("test modes done");
    globalOutputGate_n <= 1'b0;
    cyc(10);
    bw(OFS_SE_MODE, 32'h3ff);
    for (int p = 0; p < 2; p++) begin
      seed = lfsr(seed);
      pt = p ? seed[9:0] : '0;
      pc = p ? seed[19:10] : '0;
      bw(OFS_POL_TRUE, 32'(pt));
      bw(OFS_POL_COMP, 32'(pc));
      cyc(6);
      repeat (8) begin
        @(posedge clock);
        #1 chk(32'(tPin ^ cPin), 32'(pt ^ pc), "polarity");
      end
    end
    chk(32'(seMode), 32'h3ff, "se mode");
    $display("test polarity done");
    print_verdict;
  end
endmodule
